//--- dpm_i2c_host.sv
// Serial bus host model that probes the address decoder
`timescale 1ns/1ps
module dpm_i2c_host (
	input wire logic sda_oe,
	output logic scl,
	output wire logic sda
);
	logic drv;
	// Pulled up line: either party pulls low
	assign sda = drv & ~sda_oe;
	initial
	begin
		scl = 1'b1;
		drv = 1'b1;
	end
	task automatic addr_frame(input logic [6:0] a, output logic ack);
		logic [8:0] b;
		b = {a, 2'b01};
		// Half a nanosecond off the grid keeps pin moves off the clock edges
		#63 drv = 1'b0;
		#62.5 scl = 1'b0;
		for (int i = 8; i >= 0; i--)
		begin
			#31.25 drv = b[i];
			#31.25 scl = 1'b1;
			#31.25 ack = ~sda;
			#31.25 scl = 1'b0;
		end
		#31.25 drv = 1'b0;
		#31.25 scl = 1'b1;
		#62.5 drv = 1'b1;
	endtask : addr_frame
endmodule : dpm_i2c_host

//--- dpm_pkg.sv
// Constants and carrier types of the dual power monitor sequencer
// Summary of operation
// - Every converter runs 8 or 12 bit
// - 12 bit: current 33ms, voltage 16ms
// - 8 bit cuts conversion time sixteenfold
// - Scan mode cycles selected voltages round robin
// - New result sets a new-data status flag
// - Pins: input or open drain, ready, alert
// - Keep minimum and maximum of every value
// - Window miss logs fault, enabled alert low
// - Latch supply voltage at current conversion start
// - Each modulator one adds voltage to power
// - Update voltages from latch, form totals
// - Totals drop their least significant bit
// - Default: offset then current, six voltages
// - Offset phase captures no load current
// - Default calibrates before every current conversion
// - Control write with bit7: one calibration only
// - Six input scan refreshes each at 10Hz
// - Bits 4:3 shrink scan; two inputs 30Hz
// - Snapshot: one voltage or one pair
// - Snapshot end halts converters, sets flags
// - Two three-level straps give nine addresses
// - Mode 00 scan, 01 snapshot, 10 single cycle
// - Ready pin latches or drops 16/128us
// - Shutdown by register write stops conversions
// - Serial data split into input and output
package dpm_pkg;
	localparam int CLK_HZ = 100000000;
	localparam int ICONV_MS = 33;
	localparam int VCONV_MS = 16;
	localparam int ICONV_CYC = ICONV_MS * (CLK_HZ / 1000);
	localparam int VCONV_CYC = VCONV_MS * (CLK_HZ / 1000);
	localparam int LORES_DIV = 16;
	localparam int RDY_SHORT_US = 16;
	localparam int RDY_LONG_US = 128;
	localparam int RDY_SHORT_CYC = RDY_SHORT_US * (CLK_HZ / 1000000);
	localparam int RDY_LONG_CYC = RDY_LONG_US * (CLK_HZ / 1000000);
	localparam int NVAL = 10;
	localparam int IDX_I1 = 0;
	localparam int IDX_I2 = 1;
	localparam int IDX_S1 = 2;
	localparam int IDX_G1 = 4;
	localparam int IDX_P1 = 8;
	localparam int IDX_P2 = 9;
	localparam logic [8:0] OFF_CTRL = 9'h000;
	localparam logic [8:0] OFF_STATUS = 9'h004;
	localparam logic [8:0] OFF_FAULT = 9'h008;
	localparam logic [8:0] OFF_ALERT_EN = 9'h00c;
	localparam logic [8:0] OFF_GPIO_CFG = 9'h010;
	localparam logic [8:0] OFF_GPIO_IN = 9'h014;
	localparam logic [8:0] OFF_CFG = 9'h018;
	localparam logic [8:0] OFF_BUS_ADDR = 9'h01c;
	localparam logic [8:0] OFF_TOT_I = 9'h020;
	localparam logic [8:0] OFF_TOT_P = 9'h024;
	localparam logic [8:0] OFF_VAL = 9'h040;
	localparam logic [8:0] OFF_MIN = 9'h080;
	localparam logic [8:0] OFF_MAX = 9'h0c0;
	localparam logic [8:0] OFF_LO = 9'h100;
	localparam logic [8:0] OFF_HI = 9'h140;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [23:0] MIN_RST = 24'hffffff;
	localparam logic [23:0] HI_RST = 24'hffffff;
	localparam logic [1:0] MODE_SCAN = 2'h0;
	localparam logic [1:0] MODE_SNAP = 2'h1;
	localparam logic [1:0] MODE_ONCE = 2'h2;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef struct packed {
		logic awvalid;
		logic [8:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [8:0] araddr;
		logic rready;
	} dpm_axi_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} dpm_axi_rsp_t;
endpackage : dpm_pkg

//--- dpm_seq.sv
// Conversion sequencer, result store, pins and bus slave of the power monitor
`timescale 1ns/1ps
module dpm_seq #(
	parameter int ICONV_CYC = dpm_pkg::ICONV_CYC,
	parameter int VCONV_CYC = dpm_pkg::VCONV_CYC,
	parameter int RDY_LONG_CYC = dpm_pkg::RDY_LONG_CYC,
	// Arbitrary base of the nine serial addresses
	parameter logic [6:0] BUS_ADDR_BASE = 7'h48
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire dpm_pkg::dpm_axi_req_t axi_req,
	output dpm_pkg::dpm_axi_rsp_t axi_rsp,
	input wire logic current1_modulator,
	input wire logic current2_modulator,
	input wire logic modulator_stb,
	input wire logic [11:0] voltage_converter_data,
	output logic [2:0] voltage_converter_sel,
	output logic voltage_converter_busy,
	input wire logic [3:0] gpio_i,
	output logic [3:0] gpio_o,
	output logic [3:0] gpio_oe,
	input wire logic scl,
	input wire logic serial_data_in_pin,
	output logic serial_data_out_pin,
	output logic serial_data_out_oe,
	input wire logic [1:0] addr_strap_high,
	input wire logic [1:0] addr_strap_low
);
	import dpm_pkg::*;

	typedef enum logic [1:0] {SER_IDLE, SER_ADDR, SER_ACK, SER_SKIP} dpm_ser_t;

	typedef struct packed {
		dpm_axi_rsp_t rsp;
		logic aw_have;
		logic w_have;
		logic [8:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [7:0] ctrl;
		logic [9:0] status;
		logic [19:0] fault;
		logic [19:0] alert_en;
		logic [7:0] gcfg;
		logic [1:0] cfg;
		logic [9:0][23:0] val;
		logic [9:0][23:0] vmin;
		logic [9:0][23:0] vmax;
		logic [9:0][23:0] lo;
		logic [9:0][23:0] hi;
		logic [23:0] tot_i;
		logic [23:0] tot_p;
		logic [3:0] gin1;
		logic [3:0] gin2;
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [3:0] st1;
		logic [3:0] st2;
		logic [1:0] st_cnt;
		logic [6:0] addr;
		dpm_ser_t ser;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic sdo_oe;
		logic start;
		logic i_run;
		logic i_cal;
		logic [23:0] i_tmr;
		logic [11:0] ones1;
		logic [11:0] ones2;
		logic [11:0] off1;
		logic [11:0] off2;
		logic [23:0] acc1;
		logic [23:0] acc2;
		logic [11:0] op1;
		logic [11:0] op2;
		logic v_run;
		logic [23:0] v_tmr;
		logic [2:0] v_idx;
		logic [11:0] vsup1;
		logic [11:0] vsup2;
		logic [15:0] rdy_cnt;
		logic [3:0] oe;
	} dpm_state_t;

	dpm_state_t q;
	dpm_state_t n;

	function automatic logic [5:0] vmask(input logic [7:0] c);
		logic [5:0] m;
		m = 6'h00;
		case (c[6:5])
			MODE_SCAN:
				case (c[4:3])
					2'h0: m = 6'h3f;
					2'h1: m = 6'h03;
					2'h2: m = 6'h0c;
					default: m = 6'h3c;
				endcase
			MODE_SNAP:
				case (c[2:0])
					3'h6: m = 6'h03;
					3'h7: m = 6'h0c;
					default: m = 6'(6'h01 << c[2:0]);
				endcase
			MODE_ONCE: m = 6'h3f;
			default: m = 6'h00;
		endcase
		return m;
	endfunction : vmask

	// Next selected input after cur; top bit marks a wrap
	function automatic logic [3:0] vnext(input logic [5:0] m, input logic [2:0] cur);
		logic [3:0] r;
		logic [3:0] j;
		r = 4'hf;
		j = 4'h0;
		for (int k = 6; k >= 1; k--)
		begin
			j = 4'(cur) + 4'(k);
			r = (m[(j >= 4'h6) ? 3'(j - 4'h6) : j[2:0]]) ?
				{1'b1 & (j >= 4'h6), (j >= 4'h6) ? 3'(j - 4'h6) : j[2:0]} : r;
		end
		return r;
	endfunction : vnext

	// Supply operands come from the first two general pins
	function automatic logic sup_gpio(input logic [7:0] c);
		return (c[6:5] == MODE_SCAN && c[4]) || (c[6:5] == MODE_SNAP && c[2:0] == 3'h7);
	endfunction : sup_gpio

	function automatic logic arr_hit(input logic [8:0] a, input logic [8:0] base);
		return a[8:6] == base[8:6] && a[5:2] < 4'ha && a[1:0] == 2'h0;
	endfunction : arr_hit

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (s[b])
				r[b*8 +: 8] = d[b*8 +: 8];
		end
		return r;
	endfunction : wmerge

	always_comb
	begin
		logic [9:0] wen;
		logic [9:0][23:0] wdat;
		logic [19:0] fset;
		logic [9:0] sclr;
		logic [19:0] fclr;
		logic [31:0] wv;
		logic [5:0] m;
		logic [3:0] nx;
		logic [11:0] vd;
		logic [11:0] omax;
		logic [23:0] iend;
		logic [23:0] vend;
		logic [24:0] tsum;
		logic [1:0] sh;
		logic [1:0] sl;
		logic lores;
		logic sup_idx;
		logic rise;
		logic fall;
		logic i_only;
		logic [3:0] nf;
		logic lat;
		wen = '0;
		wdat = '0;
		fset = '0;
		sclr = '0;
		fclr = '0;
		wv = '0;
		tsum = '0;
		sh = '0;
		sl = '0;
		sup_idx = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		nf = 4'h0;
		lat = 1'b0;
		n = q;
		n.start = 1'b0;
		n.rsp.rdata = q.rsp.rdata;
		lores = q.cfg[1];
		m = vmask(q.ctrl);
		nx = vnext(m, q.v_idx);
		// Current converters only run where power is refreshed
		i_only = q.ctrl[6:5] == MODE_SCAN || q.ctrl[6:5] == MODE_ONCE ||
			(q.ctrl[6:5] == MODE_SNAP && q.ctrl[2:1] == 2'h3);
		iend = lores ? 24'(ICONV_CYC / LORES_DIV - 1) : 24'(ICONV_CYC - 1);
		vend = lores ? 24'(VCONV_CYC / LORES_DIV - 1) : 24'(VCONV_CYC - 1);
		omax = lores ? 12'h0ff : 12'hfff;
		vd = lores ? {4'h0, voltage_converter_data[11:4]} : voltage_converter_data;

		// Bus slave: address and data accepted in either order
		if (q.rsp.awready && axi_req.awvalid)
		begin
			n.aw_have = 1'b1;
			n.awaddr = axi_req.awaddr;
		end
		if (q.rsp.wready && axi_req.wvalid)
		begin
			n.w_have = 1'b1;
			n.wdata = axi_req.wdata;
			n.wstrb = axi_req.wstrb;
		end
		if (q.rsp.bvalid && axi_req.bready)
			n.rsp.bvalid = 1'b0;
		if (q.aw_have && q.w_have && !q.rsp.bvalid)
		begin
			n.aw_have = 1'b0;
			n.w_have = 1'b0;
			n.rsp.bvalid = 1'b1;
			n.rsp.bresp = RESP_OK;
			wv = wmerge(32'h0, q.wdata, q.wstrb);
			case (q.awaddr)
				OFF_CTRL:
				begin
					wv = wmerge({24'h0, q.ctrl}, q.wdata, q.wstrb);
					n.ctrl = wv[7:0];
					n.start = 1'b1;
				end
				OFF_STATUS: sclr = wv[9:0];
				OFF_FAULT: fclr = wv[19:0];
				OFF_ALERT_EN:
				begin
					wv = wmerge({12'h0, q.alert_en}, q.wdata, q.wstrb);
					n.alert_en = wv[19:0];
				end
				OFF_GPIO_CFG:
				begin
					wv = wmerge({24'h0, q.gcfg}, q.wdata, q.wstrb);
					n.gcfg = wv[7:0];
				end
				OFF_CFG:
				begin
					wv = wmerge({30'h0, q.cfg}, q.wdata, q.wstrb);
					n.cfg = wv[1:0];
				end
				OFF_GPIO_IN, OFF_BUS_ADDR, OFF_TOT_I, OFF_TOT_P: n.rsp.bresp = RESP_OK;
				default:
					if (arr_hit(q.awaddr, OFF_LO))
					begin
						wv = wmerge({8'h0, q.lo[q.awaddr[5:2]]}, q.wdata, q.wstrb);
						n.lo[q.awaddr[5:2]] = wv[23:0];
					end
					else if (arr_hit(q.awaddr, OFF_HI))
					begin
						wv = wmerge({8'h0, q.hi[q.awaddr[5:2]]}, q.wdata, q.wstrb);
						n.hi[q.awaddr[5:2]] = wv[23:0];
					end
					else if (!arr_hit(q.awaddr, OFF_VAL) && !arr_hit(q.awaddr, OFF_MIN) &&
						!arr_hit(q.awaddr, OFF_MAX))
						n.rsp.bresp = RESP_ERR;
			endcase
		end
		n.rsp.awready = !n.aw_have;
		n.rsp.wready = !n.w_have;

		if (q.rsp.rvalid && axi_req.rready)
			n.rsp.rvalid = 1'b0;
		if (q.rsp.arready && axi_req.arvalid)
		begin
			n.rsp.rvalid = 1'b1;
			n.rsp.rresp = RESP_OK;
			case (axi_req.araddr)
				OFF_CTRL: n.rsp.rdata = {24'h0, q.ctrl};
				OFF_STATUS: n.rsp.rdata = {22'h0, q.status};
				OFF_FAULT: n.rsp.rdata = {12'h0, q.fault};
				OFF_ALERT_EN: n.rsp.rdata = {12'h0, q.alert_en};
				OFF_GPIO_CFG: n.rsp.rdata = {24'h0, q.gcfg};
				OFF_GPIO_IN: n.rsp.rdata = {28'h0, q.gin2};
				OFF_CFG: n.rsp.rdata = {30'h0, q.cfg};
				OFF_BUS_ADDR: n.rsp.rdata = {25'h0, q.addr};
				OFF_TOT_I: n.rsp.rdata = {8'h0, q.tot_i};
				OFF_TOT_P: n.rsp.rdata = {8'h0, q.tot_p};
				default:
					if (arr_hit(axi_req.araddr, OFF_VAL))
						n.rsp.rdata = {8'h0, q.val[axi_req.araddr[5:2]]};
					else if (arr_hit(axi_req.araddr, OFF_MIN))
						n.rsp.rdata = {8'h0, q.vmin[axi_req.araddr[5:2]]};
					else if (arr_hit(axi_req.araddr, OFF_MAX))
						n.rsp.rdata = {8'h0, q.vmax[axi_req.araddr[5:2]]};
					else if (arr_hit(axi_req.araddr, OFF_LO))
						n.rsp.rdata = {8'h0, q.lo[axi_req.araddr[5:2]]};
					else if (arr_hit(axi_req.araddr, OFF_HI))
						n.rsp.rdata = {8'h0, q.hi[axi_req.araddr[5:2]]};
					else
					begin
						n.rsp.rdata = 32'h0;
						n.rsp.rresp = RESP_ERR;
					end
			endcase
		end
		n.rsp.arready = !n.rsp.rvalid;

		// Current converters: offset phase, then load current and power
		if (q.start)
		begin
			n.i_run = i_only;
			n.i_cal = 1'b1;
			n.i_tmr = '0;
			n.ones1 = '0;
			n.ones2 = '0;
		end
		else if (q.i_run && !q.cfg[0])
		begin
			n.i_tmr = q.i_tmr + 24'h1;
			if (modulator_stb)
			begin
				n.ones1 = (current1_modulator && q.ones1 < omax) ? q.ones1 + 12'h1 : q.ones1;
				n.ones2 = (current2_modulator && q.ones2 < omax) ? q.ones2 + 12'h1 : q.ones2;
				if (!q.i_cal)
				begin
					n.acc1 = current1_modulator ? q.acc1 + 24'(q.op1) : q.acc1;
					n.acc2 = current2_modulator ? q.acc2 + 24'(q.op2) : q.acc2;
				end
			end
			if (q.i_tmr == iend)
			begin
				n.i_tmr = '0;
				n.ones1 = '0;
				n.ones2 = '0;
				n.acc1 = '0;
				n.acc2 = '0;
				// Operands latch after the voltage block so a result ending now counts
				lat = 1'b1;
				if (q.i_cal)
				begin
					n.off1 = q.ones1;
					n.off2 = q.ones2;
					n.i_cal = 1'b0;
				end
				else
				begin
					wen[IDX_I1] = 1'b1;
					wen[IDX_I2] = 1'b1;
					wen[IDX_P1] = 1'b1;
					wen[IDX_P2] = 1'b1;
					wdat[IDX_I1] = (q.ones1 > q.off1) ? 24'(q.ones1 - q.off1) : 24'h0;
					wdat[IDX_I2] = (q.ones2 > q.off2) ? 24'(q.ones2 - q.off2) : 24'h0;
					wdat[IDX_P1] = q.acc1;
					wdat[IDX_P2] = q.acc2;
					sup_idx = sup_gpio(q.ctrl);
					wen[sup_idx ? IDX_G1 : IDX_S1] = 1'b1;
					wen[sup_idx ? IDX_G1 + 1 : IDX_S1 + 1] = 1'b1;
					wdat[sup_idx ? IDX_G1 : IDX_S1] = 24'(q.op1);
					wdat[sup_idx ? IDX_G1 + 1 : IDX_S1 + 1] = 24'(q.op2);
					n.i_run = q.ctrl[6:5] == MODE_SCAN;
					n.i_cal = !q.ctrl[7];
				end
			end
		end

		// Voltage converter walks its selected inputs
		if (q.start)
		begin
			n.v_run = m != 6'h00;
			nf = vnext(m, 3'h5);
			n.v_idx = nf[2:0];
			n.v_tmr = '0;
		end
		else if (q.v_run && !q.cfg[0])
		begin
			n.v_tmr = q.v_tmr + 24'h1;
			if (q.v_tmr == vend)
			begin
				n.v_tmr = '0;
				sup_idx = sup_gpio(q.ctrl) ? (q.v_idx == 3'h2 || q.v_idx == 3'h3) :
					(q.v_idx == 3'h0 || q.v_idx == 3'h1);
				if (sup_idx && q.v_idx[0])
					n.vsup2 = vd;
				else if (sup_idx)
					n.vsup1 = vd;
				// Supply results wait for the power update unless power is idle
				if (!(sup_idx && q.i_run))
				begin
					wen[IDX_S1 + int'(q.v_idx)] = 1'b1;
					wdat[IDX_S1 + int'(q.v_idx)] = 24'(vd);
				end
				if (q.ctrl[6:5] == MODE_SCAN || !nx[3])
					n.v_idx = nx[2:0];
				else
					n.v_run = 1'b0;
			end
		end

		// Newest supply results become the multiplier operands
		if (lat)
		begin
			n.op1 = n.vsup1;
			n.op2 = n.vsup2;
		end

		// One commit cycle for values, extremes, flags and totals
		for (int k = 0; k < NVAL; k++)
		begin
			if (wen[k])
			begin
				n.val[k] = wdat[k];
				n.vmin[k] = (wdat[k] < q.vmin[k]) ? wdat[k] : q.vmin[k];
				n.vmax[k] = (wdat[k] > q.vmax[k]) ? wdat[k] : q.vmax[k];
				fset[k] = wdat[k] < q.lo[k];
				fset[k + NVAL] = wdat[k] > q.hi[k];
			end
		end
		if (wen[IDX_I1])
		begin
			tsum = {1'b0, wdat[IDX_I1]} + {1'b0, wdat[IDX_I2]};
			n.tot_i = tsum[24:1];
			tsum = {1'b0, wdat[IDX_P1]} + {1'b0, wdat[IDX_P2]};
			n.tot_p = tsum[24:1];
		end
		n.status = (q.status & ~sclr) | wen;
		n.fault = (q.fault & ~fclr) | fset;

		// Ready and alert drive of the general pins
		if (|wen)
			n.rdy_cnt = q.gcfg[6:5] == 2'h1 ? 16'(RDY_SHORT_CYC) : 16'(RDY_LONG_CYC);
		else if (q.rdy_cnt != 16'h0)
			n.rdy_cnt = q.rdy_cnt - 16'h1;
		n.oe = q.gcfg[3:0];
		if (q.gcfg[4])
			n.oe[2] = (q.gcfg[6:5] == 2'h0) ? |n.status : n.rdy_cnt != 16'h0;
		if (q.gcfg[7])
			n.oe[3] = |(n.fault & q.alert_en);

		// Pin samplers, two stages before any use
		n.gin1 = gpio_i;
		n.gin2 = q.gin1;
		n.scl_s = {q.scl_s[1:0], scl};
		n.sda_s = {q.sda_s[1:0], serial_data_in_pin};
		n.st1 = {addr_strap_high, addr_strap_low};
		n.st2 = q.st1;
		// Straps are caught in the first three cycles after reset, the last one after the samplers have filled
		if (q.st_cnt != 2'h3)
		begin
			n.st_cnt = q.st_cnt + 2'h1;
			sh = (q.st2[3:2] == 2'h3) ? 2'h2 : q.st2[3:2];
			sl = (q.st2[1:0] == 2'h3) ? 2'h2 : q.st2[1:0];
			n.addr = BUS_ADDR_BASE + 7'(sh) * 7'h3 + 7'(sl);
		end

		// Serial responder: acknowledges only its own address
		rise = q.scl_s[1] && !q.scl_s[2];
		fall = !q.scl_s[1] && q.scl_s[2];
		if (q.scl_s[1] && q.scl_s[2] && q.sda_s[2] && !q.sda_s[1])
		begin
			n.ser = SER_ADDR;
			n.bitcnt = 4'h0;
			n.sdo_oe = 1'b0;
		end
		else if (q.scl_s[1] && q.scl_s[2] && !q.sda_s[2] && q.sda_s[1])
		begin
			n.ser = SER_IDLE;
			n.sdo_oe = 1'b0;
		end
		else
		begin
			case (q.ser)
				SER_ADDR:
					if (rise)
					begin
						n.shreg = {q.shreg[6:0], q.sda_s[1]};
						n.bitcnt = q.bitcnt + 4'h1;
					end
					else if (fall && q.bitcnt == 4'h8)
					begin
						n.sdo_oe = q.shreg[7:1] == q.addr;
						n.ser = (q.shreg[7:1] == q.addr) ? SER_ACK : SER_SKIP;
					end
				SER_ACK:
					if (fall)
					begin
						n.sdo_oe = 1'b0;
						n.ser = SER_SKIP;
					end
				SER_SKIP: n.sdo_oe = 1'b0;
				default: n.sdo_oe = 1'b0;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			q <= '0;
			q.rsp.awready <= 1'b1;
			q.rsp.wready <= 1'b1;
			q.rsp.arready <= 1'b1;
			q.ctrl <= CTRL_RST;
			q.vmin <= {NVAL{MIN_RST}};
			q.hi <= {NVAL{HI_RST}};
			q.ser <= SER_IDLE;
			q.scl_s <= 3'h7;
			q.sda_s <= 3'h7;
			// Power-up behaves like a write of the default control value
			q.start <= 1'b1;
		end
		else
			q <= n;
	end

	assign axi_rsp = q.rsp;
	assign voltage_converter_sel = q.v_idx;
	assign voltage_converter_busy = q.v_run;
	assign gpio_o = 4'h0;
	assign gpio_oe = q.oe;
	assign serial_data_out_pin = 1'b0;
	assign serial_data_out_oe = q.sdo_oe;
endmodule : dpm_seq

//--- dpm_seq_sva.sv
// Port checks for the power monitor sequencer
`timescale 1ns/1ps
module dpm_seq_sva
	import dpm_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire dpm_pkg::dpm_axi_req_t axi_req,
	input wire dpm_pkg::dpm_axi_rsp_t axi_rsp,
	input wire logic [2:0] voltage_converter_sel,
	input wire logic voltage_converter_busy,
	input wire logic [3:0] gpio_o,
	input wire logic scl,
	input wire logic serial_data_out_pin,
	input wire logic serial_data_out_oe
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	sequence wr_taken;
		axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
	endsequence
	sequence rd_taken;
		axi_req.arvalid && axi_rsp.arready;
	endsequence
	chk_write_answer: assert property (wr_taken |-> ##[1:2] axi_rsp.bvalid)
		else $error("write response missing");
	chk_bresp_held: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
		else $error("write response dropped");
	chk_read_answer: assert property (rd_taken |=> axi_rsp.rvalid && !axi_rsp.arready)
		else $error("read response missing");
	chk_rdata_held: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
		else $error("read data changed while waiting");
	chk_power_up: assert property ($rose(nrst) |-> ##[0:2] (voltage_converter_busy && voltage_converter_sel == 3'h0))
		else $error("no conversion start after reset");
	chk_sel_range: assert property (voltage_converter_busy |-> voltage_converter_sel <= 3'h5)
		else $error("voltage input out of range");
	// A control write may restart the scan right after an input change
	chk_sel_hold: assert property ($changed(voltage_converter_sel) && !axi_rsp.bvalid |=> $stable(voltage_converter_sel))
		else $error("voltage input held one cycle only");
	chk_pins_open: assert property (gpio_o == 4'h0 && serial_data_out_pin == 1'b0)
		else $error("open drain pin drives high");
	chk_ack_scl_low: assert property ($changed(serial_data_out_oe) |-> !scl)
		else $error("data line moved with clock high");
endmodule : dpm_seq_sva
bind dpm_seq dpm_seq_sva i_sva (
	.mclk(mclk), .nrst(nrst), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.voltage_converter_sel(voltage_converter_sel), .voltage_converter_busy(voltage_converter_busy),
	.gpio_o(gpio_o), .scl(scl), .serial_data_out_pin(serial_data_out_pin),
	.serial_data_out_oe(serial_data_out_oe)
);

//--- testbench.sv
// Self-checking bench for the power monitor sequencer
`timescale 1ns/1ps
module testbench;
	import dpm_pkg::*;
	localparam int IC = 64;
	localparam int VC = 32;
	localparam int RC = 40;
	typedef struct packed {
		logic [31:0] mask;
		logic [33:0] val;
	} dpm_tb_exp_t;
	logic mclk, nrst, m1, m2, stb, busy, scl, sda_oe, ack;
	wire sda;
	dpm_axi_req_t req;
	dpm_axi_rsp_t rsp;
	logic [11:0] vdata, v, mn4, mx4;
	logic [11:0] sv[2];
	logic [2:0] sel, c, p;
	logic [2:0] codes[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h2};
	logic [3:0] gp_ext, gp_oe;
	logic [31:0] lfsr, r32;
	dpm_tb_exp_t exp_q[$];
	dpm_tb_exp_t e;
	int bad_count, n_compared, cnt;
	dpm_seq #(.ICONV_CYC(IC), .VCONV_CYC(VC), .RDY_LONG_CYC(RC)) i_dut (
		.mclk(mclk), .nrst(nrst), .axi_req(req), .axi_rsp(rsp),
		.current1_modulator(m1), .current2_modulator(m2), .modulator_stb(stb),
		.voltage_converter_data(vdata), .voltage_converter_sel(sel), .voltage_converter_busy(busy),
		.gpio_i(gp_ext & ~gp_oe), .gpio_o(), .gpio_oe(gp_oe), .scl(scl), .serial_data_in_pin(sda),
		.serial_data_out_pin(), .serial_data_out_oe(sda_oe),
		.addr_strap_high(2'h2), .addr_strap_low(2'h1)
	);
	dpm_i2c_host i_host (.sda_oe(sda_oe), .scl(scl), .sda(sda));
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd
	task automatic chk(input logic [33:0] got, input logic [33:0] want);
		n_compared++;
		if (got !== want)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, want);
		end
	endtask : chk
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OK);
		exp_q.push_back({32'h0, r, 32'h0});
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.bready <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (rsp.awready)
				req.awvalid <= 1'b0;
			if (rsp.wready)
				req.wvalid <= 1'b0;
		end
		while (!rsp.bvalid);
		req.bready <= 1'b0;
		@(posedge mclk);
	endtask : wr
	task automatic rd(input logic [8:0] a, input logic [31:0] m, input logic [31:0] d,
		input logic [1:0] r = RESP_OK);
		exp_q.push_back({m, r, d & m});
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (rsp.arready)
				req.arvalid <= 1'b0;
		end
		while (!rsp.rvalid);
		req.rready <= 1'b0;
		@(posedge mclk);
	endtask : rd
	task automatic wait_idle(output int k);
		k = 0;
		while (busy && k < 5000)
		begin
			@(posedge mclk);
			k++;
		end
	endtask : wait_idle
	always @(posedge mclk)
	begin
		if ((rsp.rvalid && req.rready) || (rsp.bvalid && req.bready))
		begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
			if (rsp.rvalid && req.rready)
				chk({rsp.rresp, rsp.rdata & e.mask}, e.val);
			else
				chk({rsp.bresp, 32'h0}, e.val);
		end
	end
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial
	begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		test_done();
	end
	initial
	begin
		lfsr = 32'h2013;
		nrst = 1'b0;
		req = '0;
		req.wstrb = 4'hf;
		{m1, m2, stb} = 3'h0;
		vdata = 12'h000;
		gp_ext = 4'hf;
		mn4 = 12'hfff;
		mx4 = 12'h000;
		bad_count = 0;
		n_compared = 0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		rd(OFF_CTRL, 32'hff, {24'h0, CTRL_RST});
		rd(OFF_MIN + 9'h010, 32'hffffff, {8'h0, MIN_RST});
		rd(OFF_HI + 9'h010, 32'hffffff, {8'h0, HI_RST});
		wr(OFF_CTRL, 32'h20);
		rd(9'h1fc, 32'hffffffff, 32'h0, RESP_ERR);
		wr(9'h1fc, 32'h1, RESP_ERR);
		rd(OFF_BUS_ADDR, 32'h7f, 32'h4f);
		wr(OFF_HI + 9'h010, 32'h0);
		wr(OFF_ALERT_EN, 32'h4000);
		wr(OFF_GPIO_CFG, 32'h91);
		wait_idle(cnt);
		$display("reset and bus test done");
		foreach (codes[i])
		begin
			c = codes[i];
			r32 = rnd();
			v = r32[11:0] | 12'h001;
			vdata <= v;
			wr(OFF_STATUS, 32'h3ff);
			chk(gp_oe[2], 1'b0);
			wr(OFF_CTRL, {27'h1, 2'h0, c});
			chk(sel, c);
			wait_idle(cnt);
			chk(cnt >= VC - 4 && cnt <= VC + 4, 1'b1);
			rd(OFF_VAL + {4'h0, c + 3'h2, 2'h0}, 32'hfff, {20'h0, v});
			rd(OFF_STATUS, 32'h1 << (c + 2), 32'h1 << (c + 2));
			chk(gp_oe[2], 1'b1);
			if (c == 3'h2)
			begin
				mn4 = (v < mn4) ? v : mn4;
				mx4 = (v > mx4) ? v : mx4;
				rd(OFF_MIN + 9'h010, 32'hffffff, {20'h0, mn4});
				rd(OFF_MAX + 9'h010, 32'hffffff, {20'h0, mx4});
			end
			if (c < 3'h2)
				sv[c[0]] = v;
		end
		rd(OFF_FAULT, 32'h4000, 32'h4000);
		chk(gp_oe[3], 1'b1);
		wr(OFF_FAULT, 32'h4000);
		chk(gp_oe[3], 1'b0);
		$display("snapshot test done");
		vdata <= sv[0];
		wr(OFF_CTRL, 32'h26);
		// Second supply converts its own value before the power phase
		repeat (40) @(posedge mclk);
		vdata <= sv[1];
		// Strobes only mid-measure so the offset phase counts no ones
		repeat (IC - 24) @(posedge mclk);
		{m1, m2, stb} <= 3'h7;
		repeat (32) @(posedge mclk);
		stb <= 1'b0;
		repeat (IC) @(posedge mclk);
		rd(OFF_VAL, 32'hffffff, 32'd32);
		rd(OFF_VAL + 9'h004, 32'hffffff, 32'd32);
		rd(OFF_VAL + 9'h020, 32'hffffff, {15'h0, sv[0], 5'h0});
		rd(OFF_VAL + 9'h024, 32'hffffff, {15'h0, sv[1], 5'h0});
		rd(OFF_VAL + 9'h008, 32'hfff, {20'h0, sv[0]});
		rd(OFF_VAL + 9'h00c, 32'hfff, {20'h0, sv[1]});
		rd(OFF_TOT_I, 32'hffffff, 32'd32);
		rd(OFF_TOT_P, 32'hffffff, {15'h0, {1'b0, sv[0]} + {1'b0, sv[1]}, 4'h0});
		$display("power test done");
		wr(OFF_CTRL, 32'h08);
		repeat (150)
		begin
			@(posedge mclk);
			chk(sel <= 3'h1, 1'b1);
		end
		wr(OFF_CTRL, 32'h00);
		p = sel;
		repeat (400)
		begin
			@(posedge mclk);
			if (sel !== p)
			begin
				chk(sel, (p == 3'h5) ? 3'h0 : p + 3'h1);
				p = sel;
			end
		end
		wr(OFF_CTRL, 32'h80);
		repeat (2 * IC) @(posedge mclk);
		wr(OFF_STATUS, 32'h3ff);
		repeat (IC) @(posedge mclk);
		rd(OFF_STATUS, 32'h1, 32'h1);
		wr(OFF_CTRL, 32'h40);
		wait_idle(cnt);
		chk(cnt >= 6 * VC - 4 && cnt <= 6 * VC + 4, 1'b1);
		$display("scan test done");
		wr(OFF_CFG, 32'h2);
		wr(OFF_CTRL, 32'h20);
		wait_idle(cnt);
		chk(cnt <= 4, 1'b1);
		wr(OFF_CFG, 32'h1);
		wr(OFF_STATUS, 32'h3ff);
		wr(OFF_CTRL, 32'h22);
		repeat (3 * VC) @(posedge mclk);
		rd(OFF_STATUS, 32'h3ff, 32'h0);
		wr(OFF_CFG, 32'h0);
		repeat (2 * VC) @(posedge mclk);
		rd(OFF_STATUS, 32'h10, 32'h10);
		wr(OFF_STATUS, 32'h3ff);
		wr(OFF_GPIO_CFG, 32'hd1);
		wr(OFF_CTRL, 32'h20);
		cnt = 0;
		repeat (VC + RC + 20)
		begin
			@(posedge mclk);
			cnt += int'(gp_oe[2]);
		end
		chk(cnt >= RC - 1 && cnt <= RC + 1, 1'b1);
		wr(OFF_FAULT, 32'h4000);
		r32 = rnd();
		gp_ext <= r32[3:0];
		repeat (4) @(posedge mclk);
		rd(OFF_GPIO_IN, 32'hf, {28'h0, r32[3:1], 1'b0});
		chk(gp_oe[0], 1'b1);
		$display("pin and mode test done");
		i_host.addr_frame(7'h4f, ack);
		chk(ack, 1'b1);
		i_host.addr_frame(7'h48, ack);
		chk(ack, 1'b0);
		$display("serial address test done");
		test_done();
	end
endmodule : testbench
